/* File: scc_control.sv */
// Socket-side control strobes, status sensing and reset for a sixteen-bit card.
`timescale 1ns/100ps
module scc_control
(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic cmd_valid, // Host requests a card cycle.
  input wire scc_pkg::scc_cmd_e cmd_kind, // Kind of card cycle.
  input wire logic cmd_last, // Final DMA transfer, raises terminal count.
  input wire logic memory_only_mode, // Socket and card set for memory-only use.
  input wire logic dma_enable, // DMA to the card is in use.
  input wire logic host_card_reset, // Host asks for a card hard reset.
  input wire logic wait_n, // Card wait line, active low.
  input wire logic ready_irq, // Shared ready and interrupt request line.
  input wire logic write_protect_in, // Shared write-protect line.
  input wire logic voltage_sense_one, // First voltage-sense line.
  input wire logic voltage_sense_two, // Second voltage-sense line.
  output logic cmd_ready, // Controller idle and able to take a cycle.
  output logic cycle_sample, // Pulse where read data is valid on the bus.
  output logic cycle_done, // Pulse when a card cycle has finished.
  output logic oe_n, // Output enable, active low.
  output logic we_n, // Write enable, active low.
  output logic reg_n, // Attribute select and DMA acknowledge, active low.
  output logic io_read_strobe_n, // I/O read strobe, active low.
  output logic io_write_strobe_n, // I/O write strobe, active low.
  output logic card_reset, // Card hard reset, active high.
  output logic card_ready, // Memory card ready.
  output logic card_interrupt_request, // I/O card wants service.
  output logic write_protected, // Memory card write-protect switch set.
  output logic port_sixteen_bit_ack, // Addressed I/O port is sixteen bits wide.
  output logic dma_request, // Card requests a DMA transfer.
  output logic [1:0] card_voltage // Settled pair of voltage-sense levels.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [scc_pkg::SYNC_LANES-1:0] raw_in;
  logic [scc_pkg::SYNC_LANES-1:0] sync_one;
  logic [scc_pkg::SYNC_LANES-1:0] sync_two;

  assign raw_in[scc_pkg::LANE_WAIT] = wait_n;
  assign raw_in[scc_pkg::LANE_READY_IRQ] = ready_irq;
  assign raw_in[scc_pkg::LANE_PROTECT] = write_protect_in;
  assign raw_in[scc_pkg::LANE_SENSE_ONE] = voltage_sense_one;
  assign raw_in[scc_pkg::LANE_SENSE_TWO] = voltage_sense_two;

  genvar lane;
  generate
    for (lane = 0; lane < scc_pkg::SYNC_LANES; lane++)
    begin : g_sync
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_one[lane] <= 1'h1;
          sync_two[lane] <= 1'h1;
        end
        else
        begin
          sync_one[lane] <= raw_in[lane]; // [R22]
          sync_two[lane] <= sync_one[lane]; // [R22]
        end
      end
    end
  endgenerate

  wire wait_active = !sync_two[scc_pkg::LANE_WAIT];
  wire line_ready_irq = sync_two[scc_pkg::LANE_READY_IRQ];
  wire line_protect = sync_two[scc_pkg::LANE_PROTECT];
  wire [1:0] sense_pair = {sync_two[scc_pkg::LANE_SENSE_TWO], sync_two[scc_pkg::LANE_SENSE_ONE]};

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  scc_pkg::scc_state_e state;
  scc_pkg::scc_state_e next_state;
  scc_pkg::scc_cmd_e kind;
  logic last;
  logic [scc_pkg::COUNT_WIDTH-1:0] count;
  logic [scc_pkg::COUNT_WIDTH-1:0] next_count;

  localparam logic [scc_pkg::COUNT_WIDTH-1:0] SETUP_LOAD = 4'(scc_pkg::SETUP_CYCLES - 1);
  localparam logic [scc_pkg::COUNT_WIDTH-1:0] STROBE_LOAD = 4'(scc_pkg::STROBE_CYCLES - 1);
  localparam logic [scc_pkg::COUNT_WIDTH-1:0] HOLD_LOAD = 4'(scc_pkg::HOLD_CYCLES - 1);

  wire accept = (state == scc_pkg::SCC_IDLE) && cmd_valid;
  wire count_zero = (count == 4'h0);
  wire strobe_end = (state == scc_pkg::SCC_STROBE) && count_zero && !wait_active; // [R14]

  always_comb
  begin
    next_state = state;
    next_count = count;
    unique case (state)
      scc_pkg::SCC_IDLE:
      begin
        if (cmd_valid)
        begin
          next_state = scc_pkg::SCC_SETUP;
          next_count = SETUP_LOAD;
        end
      end
      scc_pkg::SCC_SETUP:
      begin
        if (count_zero)
        begin
          next_state = scc_pkg::SCC_STROBE;
          next_count = STROBE_LOAD;
        end
        else
          next_count = count - 4'h1;
      end
      scc_pkg::SCC_STROBE:
      begin
        if (!count_zero)
          next_count = count - 4'h1;
        else if (!wait_active) // [R14]
        begin
          next_state = scc_pkg::SCC_HOLD;
          next_count = HOLD_LOAD;
        end
      end
      scc_pkg::SCC_HOLD:
      begin
        if (count_zero)
          next_state = scc_pkg::SCC_IDLE;
        else
          next_count = count - 4'h1;
      end
    endcase
  end

  // The command kind is taken from the port on acceptance so that strobes for the
  // first cycle already match the new command.
  wire scc_pkg::scc_cmd_e next_kind = accept ? cmd_kind : kind;
  wire next_last = accept ? cmd_last : last;

  wire k_mem_rd = (next_kind == scc_pkg::SCC_MEM_RD) || (next_kind == scc_pkg::SCC_ATTR_RD);
  wire k_mem_wr = (next_kind == scc_pkg::SCC_MEM_WR) || (next_kind == scc_pkg::SCC_ATTR_WR);
  wire k_attr = (next_kind == scc_pkg::SCC_ATTR_RD) || (next_kind == scc_pkg::SCC_ATTR_WR);
  wire k_io_rd = (next_kind == scc_pkg::SCC_IO_RD);
  wire k_io_wr = (next_kind == scc_pkg::SCC_IO_WR);
  wire k_dma_rd = (next_kind == scc_pkg::SCC_DMA_RD);
  wire k_dma_wr = (next_kind == scc_pkg::SCC_DMA_WR);

  wire next_busy = (next_state != scc_pkg::SCC_IDLE);
  wire next_strobe = (next_state == scc_pkg::SCC_STROBE);

  wire oe_on = next_strobe && (k_mem_rd || (k_dma_wr && next_last)); // [R1] [R2]
  wire we_on = next_strobe && (k_mem_wr || (k_dma_rd && next_last)); // [R15] [R16]
  wire io_read_on = next_strobe && (k_io_rd || k_dma_wr); // [R20] [R11]
  wire io_write_on = next_strobe && (k_io_wr || k_dma_rd); // [R21] [R11]
  // Common memory leaves attribute select high for the whole cycle.
  wire reg_on = next_busy && // [R8] [R9] [R10]
    (k_attr || k_io_rd || k_io_wr || k_dma_rd || k_dma_wr);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= scc_pkg::SCC_IDLE;
      count <= 4'h0;
      kind <= scc_pkg::SCC_MEM_RD;
      last <= 1'h0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      kind <= next_kind;
      last <= next_last;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_n <= scc_pkg::STROBE_IDLE;
      we_n <= scc_pkg::STROBE_IDLE;
      reg_n <= scc_pkg::STROBE_IDLE;
      io_read_strobe_n <= scc_pkg::STROBE_IDLE;
      io_write_strobe_n <= scc_pkg::STROBE_IDLE;
      cmd_ready <= 1'h0;
      cycle_sample <= 1'h0;
      cycle_done <= 1'h0;
    end
    else
    begin
      oe_n <= !oe_on; // [R22]
      we_n <= !we_on;
      reg_n <= !reg_on;
      io_read_strobe_n <= !io_read_on;
      io_write_strobe_n <= !io_write_on;
      cmd_ready <= !next_busy;
      cycle_sample <= strobe_end;
      cycle_done <= (state == scc_pkg::SCC_HOLD) && count_zero;
    end
  end

  // ----------------------------------------------------------------
  // Status sensing and card reset
  // ----------------------------------------------------------------
  logic [1:0] sense_prev;
  wire sense_settled = (sense_pair == sense_prev); // [R13]

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_reset <= scc_pkg::CARD_RESET_AT_RESET;
      card_ready <= 1'h0;
      card_interrupt_request <= 1'h0;
      write_protected <= 1'h0;
      port_sixteen_bit_ack <= 1'h0;
      dma_request <= 1'h0;
      sense_prev <= scc_pkg::SENSE_AT_RESET;
      card_voltage <= scc_pkg::SENSE_AT_RESET;
    end
    else
    begin
      card_reset <= host_card_reset; // [R12]
      card_ready <= memory_only_mode && line_ready_irq; // [R3] [R4] [R5]
      card_interrupt_request <= !memory_only_mode && !line_ready_irq; // [R6] [R7]
      write_protected <= memory_only_mode && line_protect; // [R17]
      port_sixteen_bit_ack <= !memory_only_mode && !dma_enable && !line_protect; // [R18]
      dma_request <= dma_enable && line_protect; // [R19]
      sense_prev <= sense_pair;
      if (sense_settled)
        card_voltage <= sense_pair; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    (state == scc_pkg::SCC_IDLE) && cmd_valid;
  endsequence

  sequence s_setup_then_strobe;
    (state == scc_pkg::SCC_SETUP) [*2] ##1 (state == scc_pkg::SCC_STROBE);
  endsequence

  a_cycle_setup_order: assert property (s_accept |=> s_setup_then_strobe) // [R22]
    else $error("Setup phase not two cycles before strobe.");

  a_oe_read_only: assert property (!oe_n |-> (state == scc_pkg::SCC_STROBE) && // [R1]
    (kind == scc_pkg::SCC_MEM_RD || kind == scc_pkg::SCC_ATTR_RD ||
    (kind == scc_pkg::SCC_DMA_WR && last)))
    else $error("Output enable low outside a read strobe.");

  a_term_dma_write: assert property ((state == scc_pkg::SCC_STROBE) && // [R2]
    (kind == scc_pkg::SCC_DMA_WR) && last |-> !oe_n && !io_read_strobe_n && !reg_n)
    else $error("DMA write terminal count missing on output enable.");

  a_term_dma_read: assert property ((state == scc_pkg::SCC_STROBE) && // [R16]
    (kind == scc_pkg::SCC_DMA_RD) && last |-> !we_n && !io_write_strobe_n && !reg_n)
    else $error("DMA read terminal count missing on write enable.");

  a_reg_common_high: assert property ((kind == scc_pkg::SCC_MEM_RD || // [R8]
    kind == scc_pkg::SCC_MEM_WR) |-> reg_n)
    else $error("Attribute select low during common memory access.");

  a_dma_ack_held: assert property ((state != scc_pkg::SCC_IDLE) && // [R10]
    (kind == scc_pkg::SCC_DMA_RD || kind == scc_pkg::SCC_DMA_WR) |-> !reg_n)
    else $error("DMA acknowledge not held through DMA cycle.");

  a_wait_holds: assert property ((state == scc_pkg::SCC_STROBE) && count_zero && // [R14]
    wait_active |=> (state == scc_pkg::SCC_STROBE) && $stable(io_read_strobe_n) && $stable(oe_n))
    else $error("Cycle left strobe while wait asserted.");

  a_strobe_length: assert property ($fell(we_n) |-> !we_n [*3]) // [R15]
    else $error("Write enable pulse shorter than three cycles.");

  a_ready_gated: assert property (card_ready |-> $past(memory_only_mode)) // [R3]
    else $error("Ready reported outside memory-only mode.");

  a_reset_follow: assert property (host_card_reset |=> card_reset) // [R12]
    else $error("Card reset did not follow the host request.");

  a_voltage_pair: assert property ($changed(card_voltage) |-> // [R13]
    card_voltage == $past(sense_pair, 2))
    else $error("Voltage pair updated from an unsettled sample.");

  a_sample_strobe_off: assert property (cycle_sample |-> // [R14]
    (state == scc_pkg::SCC_HOLD) && oe_n && we_n && io_read_strobe_n && io_write_strobe_n)
    else $error("Sample pulse while a data strobe still low.");

  a_done_idle: assert property (cycle_done |-> // [R10]
    (state == scc_pkg::SCC_IDLE) && cmd_ready && reg_n)
    else $error("Cycle done without a return to idle.");

  a_irq_gated: assert property (card_interrupt_request |-> !$past(memory_only_mode)) // [R3]
    else $error("Interrupt request reported in memory-only mode.");

  a_io_read_kind: assert property (!io_read_strobe_n |-> // [R20]
    (state == scc_pkg::SCC_STROBE) &&
    (kind == scc_pkg::SCC_IO_RD || kind == scc_pkg::SCC_DMA_WR))
    else $error("I/O read strobe outside an I/O read or DMA write.");

  a_io_write_kind: assert property (!io_write_strobe_n |-> // [R21]
    (state == scc_pkg::SCC_STROBE) &&
    (kind == scc_pkg::SCC_IO_WR || kind == scc_pkg::SCC_DMA_RD))
    else $error("I/O write strobe outside an I/O write or DMA read.");

endmodule

/* File: scc_pkg.sv */
// Constants, types and timing counts for the sixteen-bit card control signalling.
//
// Function
// R1: Output enable low during memory reads.
// R2: Output enable marks DMA write terminal count.
// R3: Shared line is ready only in memory mode.
// R4: Busy memory card holds ready low.
// R5: Memory card drives ready high when free.
// R6: I/O card asserts interrupt request for service.
// R7: Interrupt request stays high when idle.
// R8: Attribute select high for common memory.
// R9: Attribute select steers attribute or I/O space.
// R10: Attribute select is DMA acknowledge during DMA.
// R11: DMA data moves with acknowledge plus strobe.
// R12: Card reset output forces hard reset.
// R13: Voltage from both sense lines together.
// R14: Wait asserted holds the cycle open.
// R15: Write enable strobes memory write data.
// R16: Write enable marks DMA read terminal count.
// R17: Write protect reflects card switch.
// R18: I/O card flags sixteen-bit port on write protect.
// R19: DMA card requests DMA on write protect.
// R20: I/O read strobe is the DMA write strobe.
// R21: I/O write strobe for DMA from host memory.
// R22: Active-low strobes; card inputs synchronised.
package scc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SETUP_TIME_NS = 20;
  localparam int STROBE_TIME_NS = 30;
  localparam int HOLD_TIME_NS = 20;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int COUNT_WIDTH = 4;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_LANES = 5;
  localparam int LANE_WAIT = 0;
  localparam int LANE_READY_IRQ = 1;
  localparam int LANE_PROTECT = 2;
  localparam int LANE_SENSE_ONE = 3;
  localparam int LANE_SENSE_TWO = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic CARD_RESET_AT_RESET = 1'h1;
  localparam logic [1:0] SENSE_AT_RESET = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCC_MEM_RD,
    SCC_MEM_WR,
    SCC_ATTR_RD,
    SCC_ATTR_WR,
    SCC_IO_RD,
    SCC_IO_WR,
    SCC_DMA_RD,
    SCC_DMA_WR
  } scc_cmd_e;

  typedef enum logic [1:0] {
    SCC_IDLE,
    SCC_SETUP,
    SCC_STROBE,
    SCC_HOLD
  } scc_state_e;

endpackage

/* File: scc_card_model.sv */
// Behavioural sixteen-bit memory or I/O card seen from the socket.
`timescale 1ns/100ps
module scc_card_model
(
  input wire logic clock, // System clock.
  input wire logic strobe_n, // Any data strobe from the socket, active low.
  input wire logic card_io, // High for an I/O card, low for a memory card.
  input wire logic busy, // Memory card still finishing a write.
  input wire logic irq, // I/O card wants service.
  input wire logic protect, // Write-protect switch set.
  input wire logic port_wide, // Addressed I/O port is sixteen bits wide.
  input wire logic dma_req, // Card wants a DMA transfer.
  input wire logic [3:0] wait_len, // Strobe cycles held in wait, zero for none.
  output logic wait_n, // Wait line, active low.
  output logic ready_irq, // Shared ready and interrupt line.
  output logic write_protect_in // Shared write-protect line.
);
  logic [3:0] held;
  always_ff @(posedge clock)
  begin
    if (strobe_n)
      held <= 4'h0;
    else if (held != 4'hF)
      held <= held + 4'h1;
  end
  // The wait line is pulled up, so it reads high outside strobes.
  assign wait_n = strobe_n || (held >= wait_len);
  assign ready_irq = card_io ? !irq : !busy;
  assign write_protect_in = card_io ? (dma_req || !port_wide) : protect;
endmodule

/* File: test_sixteen_bit_card_control_signals.sv */
// Self-checking testbench for the card control signalling block.
`timescale 1ns/100ps
module test_sixteen_bit_card_control_signals;
  logic clock, rst_n, cmd_valid, cmd_last, memory_only_mode, dma_enable, host_card_reset;
  scc_pkg::scc_cmd_e cmd_kind;
  logic wait_n, ready_irq, write_protect_in, voltage_sense_one, voltage_sense_two;
  logic cmd_ready, cycle_sample, cycle_done, oe_n, we_n, reg_n;
  logic io_read_strobe_n, io_write_strobe_n, card_reset, card_ready, card_interrupt_request;
  logic write_protected, port_sixteen_bit_ack, dma_request, strobe_n;
  logic [1:0] card_voltage;
  logic card_io, busy, irq, protect, port_wide, dma_req;
  logic [3:0] wait_len;
  int err_count, checks;

  scc_control scc_control_i (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_last(cmd_last), .memory_only_mode(memory_only_mode),
    .dma_enable(dma_enable), .host_card_reset(host_card_reset), .wait_n(wait_n),
    .ready_irq(ready_irq), .write_protect_in(write_protect_in),
    .voltage_sense_one(voltage_sense_one), .voltage_sense_two(voltage_sense_two),
    .cmd_ready(cmd_ready), .cycle_sample(cycle_sample), .cycle_done(cycle_done),
    .oe_n(oe_n), .we_n(we_n), .reg_n(reg_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .card_reset(card_reset), .card_ready(card_ready),
    .card_interrupt_request(card_interrupt_request), .write_protected(write_protected),
    .port_sixteen_bit_ack(port_sixteen_bit_ack), .dma_request(dma_request),
    .card_voltage(card_voltage));
  assign strobe_n = oe_n & we_n & io_read_strobe_n & io_write_strobe_n;
  scc_card_model scc_card_model_i (.clock(clock), .strobe_n(strobe_n), .card_io(card_io),
    .busy(busy), .irq(irq), .protect(protect), .port_wide(port_wide), .dma_req(dma_req),
    .wait_len(wait_len), .wait_n(wait_n), .ready_irq(ready_irq),
    .write_protect_in(write_protect_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic summarize();
    $display("Made %0d checks, found %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Runs one card cycle; returns which strobes went low, how long they stood and the cycle count.
  task automatic run_cycle(input scc_pkg::scc_cmd_e kind, input logic last,
    output logic [4:0] lows, output int len, output int n);
    int pulses;
    lows = 5'h00;
    len = 0;
    n = 0;
    pulses = 0;
    cmd_kind = kind;
    cmd_last = last;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    check("ready while busy", 5'h00, {4'h0, cmd_ready});
    while (cycle_done !== 1'b1 && n < 100)
    begin
      lows = lows | ~{oe_n, we_n, reg_n, io_read_strobe_n, io_write_strobe_n};
      if (strobe_n === 1'b0)
        len++;
      if (cycle_sample === 1'b1)
      begin
        pulses++;
        check("strobe off at sample", 5'h01, {4'h0, strobe_n});
      end
      tick(1);
      n++;
    end
    if (n >= 100)
      err_count++;
    check("sample pulses", 5'h01, pulses[4:0]);
    check("ready after cycle", 5'h01, {4'h0, cmd_ready});
  endtask

  task automatic test_strobes();
    logic [4:0] lows;
    logic [4:0] exp;
    int len;
    int cyc;
    int exp_cyc;
    scc_pkg::scc_cmd_e k;
    exp_cyc = scc_pkg::SETUP_CYCLES + scc_pkg::STROBE_CYCLES + scc_pkg::HOLD_CYCLES;
    for (int i = 0; i < 16; i++)
    begin
      k = scc_pkg::scc_cmd_e'(i[3:1]);
      exp[4] = k == scc_pkg::SCC_MEM_RD || k == scc_pkg::SCC_ATTR_RD
        || (k == scc_pkg::SCC_DMA_WR && i[0]);
      exp[3] = k == scc_pkg::SCC_MEM_WR || k == scc_pkg::SCC_ATTR_WR
        || (k == scc_pkg::SCC_DMA_RD && i[0]);
      exp[2] = !(k == scc_pkg::SCC_MEM_RD || k == scc_pkg::SCC_MEM_WR);
      exp[1] = k == scc_pkg::SCC_IO_RD || k == scc_pkg::SCC_DMA_WR;
      exp[0] = k == scc_pkg::SCC_IO_WR || k == scc_pkg::SCC_DMA_RD;
      run_cycle(k, i[0], lows, len, cyc);
      check("strobes low", exp, lows);
      check("strobe length", 5'(scc_pkg::STROBE_CYCLES), len[4:0]);
      check("cycle length", exp_cyc[4:0], cyc[4:0]);
    end
  endtask

  task automatic test_wait();
    logic [4:0] lows;
    int len;
    int cyc;
    int exp_cyc;
    wait_len = 4'h6;
    run_cycle(scc_pkg::SCC_IO_RD, 1'b0, lows, len, cyc);
    check("strobe outlasts wait", 5'h01, {4'h0, len > 6});
    exp_cyc = len + scc_pkg::SETUP_CYCLES + scc_pkg::HOLD_CYCLES;
    check("wait cycle length", exp_cyc[4:0], cyc[4:0]);
    wait_len = 4'h0;
  endtask

  // Knobs: memory mode, I/O card, busy, irq, protect, wide port, DMA in use, DMA request.
  task automatic status_case(input logic [7:0] knobs, input logic [4:0] exp);
    {memory_only_mode, card_io, busy, irq, protect, port_wide, dma_enable, dma_req} = knobs;
    tick(4);
    check("status", exp, {card_ready, card_interrupt_request, write_protected,
      port_sixteen_bit_ack, dma_request});
  endtask

  task automatic test_status();
    status_case(8'hA0, 5'h00);
    status_case(8'h88, 5'h14);
    status_case(8'h50, 5'h08);
    status_case(8'h44, 5'h02);
    status_case(8'h43, 5'h01);
    status_case(8'h88, 5'h14);
  endtask

  task automatic test_reset_voltage();
    host_card_reset = 1'b1;
    tick(2);
    check("card reset", 5'h01, {4'h0, card_reset});
    host_card_reset = 1'b0;
    tick(2);
    check("card reset", 5'h00, {4'h0, card_reset});
    for (int v = 0; v < 4; v++)
    begin
      {voltage_sense_two, voltage_sense_one} = v[1:0];
      tick(5);
      check("card voltage", {3'h0, v[1:0]}, {3'h0, card_voltage});
    end
  endtask

  initial
  begin
    {rst_n, cmd_valid, cmd_last, memory_only_mode, dma_enable, host_card_reset} = 6'h00;
    cmd_kind = scc_pkg::SCC_MEM_RD;
    {voltage_sense_one, voltage_sense_two} = 2'h3;
    {card_io, busy, irq, protect, port_wide, dma_req} = 6'h00;
    wait_len = 4'h0;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    #1;
    check("reset outputs", 5'h1E, {card_reset, oe_n, we_n, reg_n, cmd_ready});
    rst_n = 1'b1;
    tick(2);
    test_strobes();
    test_wait();
    test_status();
    test_reset_voltage();
    summarize();
  end

  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
